// [rtl/uart_autocal_cfg.svh]
// Register offsets, field positions, reset values and timing for the serial transceiver.
`ifndef UART_AUTOCAL_CFG_SVH
`define UART_AUTOCAL_CFG_SVH

// ==========================================================
// Clock and rates
`define UA_CLK_HZ 10000000
`define UA_MAX_BPS 115200
`define UA_NUM_RATES 10
`define UA_BPS0 1200
`define UA_BPS1 2400
`define UA_BPS2 4800
`define UA_BPS3 9600
`define UA_BPS4 19200
`define UA_BPS5 38400
`define UA_BPS6 51200
`define UA_BPS7 57600
`define UA_BPS8 102400
`define UA_BPS9 115200

// ==========================================================
// Register offsets
`define UA_ADDR_CTRL 4'h0
`define UA_ADDR_STATUS 4'h1
`define UA_ADDR_MASK 4'h2
`define UA_ADDR_BAUD 4'h3
`define UA_ADDR_PRE_LO 4'h4
`define UA_ADDR_PRE_HI 4'h5
`define UA_ADDR_TXDATA 4'h6
`define UA_ADDR_RXDATA 4'h7

// ==========================================================
// Control fields
`define UA_C_TXIE 0
`define UA_C_RXIE 1
`define UA_C_PEN 2
`define UA_C_PODD 3
`define UA_C_AUTO 4
`define UA_C_EN 5

// ==========================================================
// Status fields
`define UA_S_RXDONE 0
`define UA_S_TXDONE 1
`define UA_S_FERR 2
`define UA_S_OVR 3
`define UA_S_PERR 4
`define UA_S_TXBUSY 5
`define UA_S_RXFULL 6
`define UA_STATUS_W1C 8'h1F

// ==========================================================
// Reset values
`define UA_CTRL_RST 8'h10
`define UA_MASK_RST 8'h00
`define UA_BAUD_RST 4'h3
`define UA_PRE_RST 16'h0410

`endif

// [rtl/uart_autocal_pkg.sv]
// Types and the calibrated divisor table of the serial transceiver.
`include "uart_autocal_cfg.svh"
package uart_autocal_pkg;

   // ==========================================================
   // State encodings
   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
   } tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
   } rx_state_t;

   // ==========================================================
   // Calibrated bit period, in clock cycles minus one, rounded to nearest.
   function automatic logic [15:0] calib_div(input logic [3:0] idx);
      int bps;
      bps = `UA_BPS9;
      unique case (idx)
         4'h0: bps = `UA_BPS0;
         4'h1: bps = `UA_BPS1;
         4'h2: bps = `UA_BPS2;
         4'h3: bps = `UA_BPS3;
         4'h4: bps = `UA_BPS4;
         4'h5: bps = `UA_BPS5;
         4'h6: bps = `UA_BPS6;
         4'h7: bps = `UA_BPS7;
         4'h8: bps = `UA_BPS8;
         default: bps = `UA_BPS9;
      endcase
      return 16'((`UA_CLK_HZ + bps / 2) / bps - 1);
   endfunction

endpackage

// [rtl/uart_sync3.sv]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module uart_sync3 #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // Asynchronous level in, filtered level out
   input wire logic d_in,
   output logic q_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change is accepted only once the second and third stages agree.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         q_out <= RESET_VAL;
      end else if (s2_reg == s3_reg) begin
         q_out <= s3_reg;
      end
   end
endmodule // uart_sync3

// [rtl/uart_bit_timer.sv]
// Bit-period divider giving a one-cycle enable pulse per bit.
`timescale 1ns/1ps
module uart_bit_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // Control
   input wire logic start_in,
   input wire logic half_in,
   input wire logic run_in,
   input wire logic [W-1:0] period_in,
   // Enable pulse
   output logic tick_out
);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         cnt_reg <= '0;
      end else if (start_in) begin
         cnt_reg <= half_in ? (period_in >> 1) : period_in;
      end else if (run_in) begin
         cnt_reg <= (cnt_reg == '0) ? period_in : cnt_reg - 1'b1;
      end
   end

   assign tick_out = run_in && !start_in && (cnt_reg == '0);
endmodule // uart_bit_timer

// [rtl/uart_autocal.sv]
// Serial transceiver with calibrated or prescaled baud rate and sticky status.
`timescale 1ns/1ps
`include "uart_autocal_cfg.svh"

// Overview of operation
// - One serial channel: one transmit line, one receive line.
// - Bit rates up to 115.2 kbps are supported.
// - Control register sets interrupt enables, parity on/off, parity sense, clock source.
// - Receive request on byte arrival, transmit request after byte fully sent.
// - Status register shows receive, transmit or both as interrupt cause.
// - Framing, overrun and parity errors checked per byte, flagged in status.
// - Auto calibration derives standard rates 1.2 to 115.2 kbps from the clock.
// - Calibrated rate is the last value written to the baud select setting.
// - Without calibration the bit period comes straight from the prescaler.
// - Prescaler mode allows arbitrary rates, uncorrected for clock drift.
// - Port C bit 2 carries transmit, bit 3 carries receive.
module uart_autocal
   import uart_autocal_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Port C serial pins, index 0 is bit 2, index 1 is bit 3
   input wire logic [1:0] port_c_serial_pins_in,
   output logic [1:0] port_c_serial_pins_out,
   output logic [1:0] port_c_serial_pins_oe_out,
   // Interrupts
   output logic rx_irq_out,
   output logic tx_irq_out,
   output logic irq_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   // ==========================================================
   // Registers
   logic [7:0] ctrl_reg;
   logic [7:0] mask_reg;
   logic [3:0] baud_reg;
   logic [15:0] pre_reg;
   logic [7:0] stat_reg;
   logic [7:0] stat_next;
   logic [7:0] rx_buf_reg;
   logic rx_full_reg;
   logic [15:0] bit_period;
   logic rx_line;
   logic rx_tick;
   logic tx_tick;
   logic wr_ctrl, wr_stat, wr_tx, rd_rx;
   logic tx_accept;
   logic rx_ev, tx_ev, ferr_ev, ovr_ev, perr_ev;

   assign wr_ctrl = reg_wr_in && (reg_addr_in == `UA_ADDR_CTRL);
   assign wr_stat = reg_wr_in && (reg_addr_in == `UA_ADDR_STATUS);
   assign wr_tx = reg_wr_in && (reg_addr_in == `UA_ADDR_TXDATA);
   assign rd_rx = reg_rd_in && (reg_addr_in == `UA_ADDR_RXDATA);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         ctrl_reg <= `UA_CTRL_RST;
         mask_reg <= `UA_MASK_RST;
         baud_reg <= `UA_BAUD_RST;
         pre_reg <= `UA_PRE_RST;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            `UA_ADDR_CTRL: ctrl_reg <= {2'h0, reg_wdata_in[5:0]};
            `UA_ADDR_MASK: mask_reg <= {3'h0, reg_wdata_in[4:0]};
            `UA_ADDR_BAUD: baud_reg <= reg_wdata_in[3:0];
            `UA_ADDR_PRE_LO: pre_reg[7:0] <= reg_wdata_in;
            `UA_ADDR_PRE_HI: pre_reg[15:8] <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Bit period selection
   // Calibration is against the known system clock; software must still keep
   // the clock well above the chosen rate or the rounding error grows.
   // The fastest table entry, 115.2 kbps, is about 87 cycles a bit here.
   // A raw prescaler is taken as is and follows any drift of the clock.
   assign bit_period = ctrl_reg[`UA_C_AUTO] ? calib_div(baud_reg) : pre_reg;

   // ==========================================================
   // Receiver
   rx_state_t rx_state;
   logic [7:0] rx_sh_reg;
   logic [2:0] rx_cnt_reg;
   logic rx_perr_reg;
   logic rx_begin;

   uart_sync3 #(.RESET_VAL(1'b1)) u_rx_sync (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .d_in(port_c_serial_pins_in[1]),
      .q_out(rx_line)
   );

   assign rx_begin = (rx_state == RX_IDLE) && ctrl_reg[`UA_C_EN] && !rx_line;

   uart_bit_timer #(.W(16)) u_rx_timer (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .start_in(rx_begin),
      .half_in(1'b1),
      .run_in(rx_state != RX_IDLE),
      .period_in(bit_period),
      .tick_out(rx_tick)
   );

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         rx_state <= RX_IDLE;
         rx_sh_reg <= 8'h00;
         rx_cnt_reg <= 3'h0;
         rx_perr_reg <= 1'b0;
      end else begin
         unique case (rx_state)
            RX_IDLE: if (rx_begin) begin
               rx_state <= RX_START;
            end
            // A start bit that is high again at mid-bit was a glitch.
            RX_START: if (rx_tick) begin
               rx_state <= rx_line ? RX_IDLE : RX_DATA;
               rx_cnt_reg <= 3'h0;
               rx_perr_reg <= 1'b0;
            end
            RX_DATA: if (rx_tick) begin
               rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
               rx_cnt_reg <= rx_cnt_reg + 3'h1;
               if (rx_cnt_reg == 3'h7) begin
                  rx_state <= ctrl_reg[`UA_C_PEN] ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: if (rx_tick) begin
               rx_perr_reg <= rx_line ^ (^rx_sh_reg) ^ ctrl_reg[`UA_C_PODD];
               rx_state <= RX_STOP;
            end
            RX_STOP: if (rx_tick) begin
               rx_state <= RX_IDLE;
            end
         endcase
      end
   end

   assign rx_ev = (rx_state == RX_STOP) && rx_tick;
   assign ferr_ev = rx_ev && !rx_line;
   assign perr_ev = rx_ev && rx_perr_reg;
   assign ovr_ev = rx_ev && rx_full_reg && !rd_rx;

   // The newest byte replaces an unread one; the overrun flag records the loss.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         rx_buf_reg <= 8'h00;
         rx_full_reg <= 1'b0;
      end else if (rx_ev) begin
         rx_buf_reg <= rx_sh_reg;
         rx_full_reg <= 1'b1;
      end else if (rd_rx) begin
         rx_full_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Transmitter
   tx_state_t tx_state;
   logic [7:0] tx_sh_reg;
   logic [2:0] tx_cnt_reg;
   logic tx_par_reg;
   logic tx_line_reg;

   // Writes while busy or disabled are dropped; poll the busy bit first.
   assign tx_accept = wr_tx && (tx_state == TX_IDLE) && ctrl_reg[`UA_C_EN];

   uart_bit_timer #(.W(16)) u_tx_timer (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .start_in(tx_accept),
      .half_in(1'b0),
      .run_in(tx_state != TX_IDLE),
      .period_in(bit_period),
      .tick_out(tx_tick)
   );

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         tx_state <= TX_IDLE;
         tx_sh_reg <= 8'h00;
         tx_cnt_reg <= 3'h0;
         tx_par_reg <= 1'b0;
         tx_line_reg <= 1'b1;
      end else begin
         unique case (tx_state)
            TX_IDLE: if (tx_accept) begin
               tx_sh_reg <= reg_wdata_in;
               tx_par_reg <= (^reg_wdata_in) ^ ctrl_reg[`UA_C_PODD];
               tx_cnt_reg <= 3'h0;
               tx_line_reg <= 1'b0;
               tx_state <= TX_START;
            end
            TX_START: if (tx_tick) begin
               tx_line_reg <= tx_sh_reg[0];
               tx_state <= TX_DATA;
            end
            TX_DATA: if (tx_tick) begin
               tx_sh_reg <= tx_sh_reg >> 1;
               tx_cnt_reg <= tx_cnt_reg + 3'h1;
               if (tx_cnt_reg == 3'h7) begin
                  tx_line_reg <= ctrl_reg[`UA_C_PEN] ? tx_par_reg : 1'b1;
                  tx_state <= ctrl_reg[`UA_C_PEN] ? TX_PAR : TX_STOP;
               end else begin
                  tx_line_reg <= tx_sh_reg[1];
               end
            end
            TX_PAR: if (tx_tick) begin
               tx_line_reg <= 1'b1;
               tx_state <= TX_STOP;
            end
            TX_STOP: if (tx_tick) begin
               tx_state <= TX_IDLE;
            end
         endcase
      end
   end

   assign tx_ev = (tx_state == TX_STOP) && tx_tick;

   // ==========================================================
   // Status, interrupts and pins
   // Hardware set beats a write-one clear arriving in the same cycle.
   always_comb begin
      stat_next = stat_reg & ~(wr_stat ? (reg_wdata_in & `UA_STATUS_W1C) : 8'h00);
      stat_next[`UA_S_RXDONE] = stat_next[`UA_S_RXDONE] | rx_ev;
      stat_next[`UA_S_TXDONE] = stat_next[`UA_S_TXDONE] | tx_ev;
      stat_next[`UA_S_FERR] = stat_next[`UA_S_FERR] | ferr_ev;
      stat_next[`UA_S_OVR] = stat_next[`UA_S_OVR] | ovr_ev;
      stat_next[`UA_S_PERR] = stat_next[`UA_S_PERR] | perr_ev;
      stat_next[`UA_S_TXBUSY] = 1'b0;
      stat_next[`UA_S_RXFULL] = 1'b0;
      stat_next[7] = 1'b0;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         stat_reg <= 8'h00;
      end else begin
         stat_reg <= stat_next;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         rx_irq_out <= 1'b0;
         tx_irq_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         rx_irq_out <= stat_reg[`UA_S_RXDONE] && ctrl_reg[`UA_C_RXIE];
         tx_irq_out <= stat_reg[`UA_S_TXDONE] && ctrl_reg[`UA_C_TXIE];
         irq_out <= |(stat_reg[4:0] & mask_reg[4:0]);
      end
   end

   // Only bit 2 is ever driven; bit 3 is a pure input while the channel is on.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         port_c_serial_pins_out <= 2'h1;
         port_c_serial_pins_oe_out <= 2'h0;
      end else begin
         port_c_serial_pins_out <= {1'b0, tx_line_reg};
         port_c_serial_pins_oe_out <= {1'b0, ctrl_reg[`UA_C_EN]};
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `UA_ADDR_CTRL: reg_rdata_out <= ctrl_reg;
            `UA_ADDR_STATUS: reg_rdata_out <= {1'b0, rx_full_reg, tx_state != TX_IDLE,
                                               stat_reg[4:0]};
            `UA_ADDR_MASK: reg_rdata_out <= mask_reg;
            `UA_ADDR_BAUD: reg_rdata_out <= {4'h0, baud_reg};
            `UA_ADDR_PRE_LO: reg_rdata_out <= pre_reg[7:0];
            `UA_ADDR_PRE_HI: reg_rdata_out <= pre_reg[15:8];
            `UA_ADDR_RXDATA: reg_rdata_out <= rx_buf_reg;
            default: reg_rdata_out <= 8'h00;
         endcase
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   // ==========================================================
   // Assertions
   a_tx_idle_high: assert property ((tx_state == TX_IDLE) |-> tx_line_reg)
      else $error("transmit line low while idle");
   a_tx_start_low: assert property (tx_accept |=> !tx_line_reg ##1 !port_c_serial_pins_out[0])
      else $error("start bit not driven low");
   a_tx_done_flag: assert property (tx_ev |=> stat_reg[`UA_S_TXDONE])
      else $error("transmit done not flagged");
   a_rx_done_flag: assert property (rx_ev |=> stat_reg[`UA_S_RXDONE] && rx_full_reg)
      else $error("receive done not flagged");
   a_rx_overrun: assert property (rx_ev && rx_full_reg && !rd_rx |=> stat_reg[`UA_S_OVR])
      else $error("overrun not flagged");
   a_rx_framing: assert property (rx_ev && !rx_line |=> stat_reg[`UA_S_FERR])
      else $error("framing error not flagged");
   a_set_wins: assert property (tx_ev && wr_stat && reg_wdata_in[1] |=> stat_reg[1])
      else $error("clear beat a same-cycle event");
   a_irq_follows: assert property (|(stat_reg[4:0] & mask_reg[4:0]) |=> irq_out)
      else $error("interrupt missing for unmasked status");
   a_rx_irq_gate: assert property (!ctrl_reg[`UA_C_RXIE] |=> !rx_irq_out)
      else $error("receive request while disabled");
   a_ctrl_write: assert property (wr_ctrl
                                  |=> ctrl_reg == ($past(reg_wdata_in) & 8'h3F))
      else $error("control write not taken");
   a_calib_period: assert property (ctrl_reg[`UA_C_AUTO] && baud_reg == 4'h9
                                    |-> bit_period == 16'h0056)
      else $error("wrong calibrated period at top rate");

   c_tx_frame: cover property (tx_ev);
   c_rx_frame: cover property (rx_ev && !ferr_ev);
   c_rx_overrun: cover property (ovr_ev);
   c_rx_parity: cover property (perr_ev);
endmodule // uart_autocal

// [testbench/uart_far_end.sv]
// Model of the remote serial device that faces the transceiver.
`timescale 1ns/1ps
module uart_far_end (
   // Clock
   input wire logic clk_sys_in,
   // Link settings
   input wire logic [15:0] bit_cyc_in,
   input wire logic par_en_in,
   input wire logic par_odd_in,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] got_byte;
   logic got_par_ok;
   logic [7:0] sh;
   logic pb;

   initial begin
      line_out = 1'b1;
      got_byte = 8'h00;
      got_par_ok = 1'b0;
   end

   // ==========================================================
   // Sender, which can spoil parity or the stop bit on request.
   task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
      logic [10:0] f;
      int n;
      n = par_en_in ? 11 : 10;
      f = {2'b11, d, 1'b0};
      if (par_en_in) f[9] = ^d ^ par_odd_in ^ bad_par;
      f[n-1] = ~bad_stop;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys_in);
         line_out <= f[i];
         repeat (bit_cyc_in - 1) @(posedge clk_sys_in);
      end
      @(posedge clk_sys_in);
      line_out <= 1'b1;
   endtask

   // ==========================================================
   // Receiver, sampling each bit in its middle.
   always begin
      @(posedge clk_sys_in iff line_in === 1'b0);
      repeat (bit_cyc_in / 2) @(posedge clk_sys_in);
      if (line_in === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc_in) @(posedge clk_sys_in);
            sh = {line_in, sh[7:1]};
         end
         pb = ^sh ^ par_odd_in;
         if (par_en_in) begin
            repeat (bit_cyc_in) @(posedge clk_sys_in);
            got_par_ok = (line_in === pb);
         end
         repeat (bit_cyc_in) @(posedge clk_sys_in);
         got_byte = sh;
      end
   end
endmodule // uart_far_end

// [testbench/uart_with_baud_autocal_test.sv]
// Self-checking bench for the serial transceiver with calibrated baud rates.
`timescale 1ns/1ps
`include "uart_autocal_cfg.svh"
module uart_with_baud_autocal_test;
   logic clk_sys_in, rst_b_in, reg_wr, reg_rd, far_line, par_en, par_odd;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [1:0] pins_out, pins_oe;
   logic rx_irq, tx_irq, irq;
   logic [15:0] bit_cyc;
   wire logic tx_line;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int bps_tab[3] = '{`UA_BPS9, `UA_BPS8, `UA_BPS6};
   logic [3:0] idx_tab[3] = '{4'h9, 4'h8, 4'h6};

   // The transmit pin has a pull-up, so a released pin reads high.
   assign tx_line = pins_oe[0] ? pins_out[0] : 1'b1;

   uart_autocal u_dut (
      .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
      .port_c_serial_pins_in({far_line, 1'b1}), .port_c_serial_pins_out(pins_out),
      .port_c_serial_pins_oe_out(pins_oe),
      .rx_irq_out(rx_irq), .tx_irq_out(tx_irq), .irq_out(irq));

   uart_far_end u_far (
      .clk_sys_in(clk_sys_in), .bit_cyc_in(bit_cyc), .par_en_in(par_en),
      .par_odd_in(par_odd), .line_in(tx_line), .line_out(far_line));

   always #50 clk_sys_in = ~clk_sys_in;

   // ==========================================================
   // Access and comparison tasks
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check8(d, exp);
   endtask

   // Polls status under a bounded count, since a frame at the slowest rate is long.
   task automatic wait_st(input logic [7:0] m);
      logic [7:0] s;
      int k;
      k = 0;
      s = 8'h00;
      while ((s & m) !== m && k < 2500) begin
         rd(`UA_ADDR_STATUS, s);
         k++;
      end
      check8(s & m, m);
   endtask

   task automatic tx_chk(input logic [7:0] d);
      logic [7:0] s;
      wr(`UA_ADDR_TXDATA, d);
      rd(`UA_ADDR_STATUS, s);
      check8(s & 8'h20, 8'h20);
      wait_st(8'h02);
      repeat (3) @(posedge clk_sys_in);
      check8({7'h00, tx_irq}, 8'h01);
      check8(u_far.got_byte, d);
      wr(`UA_ADDR_STATUS, 8'h02);
   endtask

   task automatic rx_chk(input logic [7:0] d, input logic bp, input logic bs,
                         input logic [7:0] st);
      logic [7:0] s;
      u_far.send(d, bp, bs);
      wait_st(8'h01);
      repeat (2) @(posedge clk_sys_in);
      check8({7'h00, rx_irq}, 8'h01);
      rd(`UA_ADDR_STATUS, s);
      check8(s & 8'h5F, st | 8'h40);
      rd_chk(`UA_ADDR_RXDATA, d);
      repeat (12 * bit_cyc) @(posedge clk_sys_in);
      rd(`UA_ADDR_RXDATA, s);
      wr(`UA_ADDR_STATUS, 8'h1F);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // Hang guard, well above the longest expected run.
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      clk_sys_in = 1'b0;
      rst_b_in = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      bit_cyc = 16'h0010;
      par_en = 1'b0;
      par_odd = 1'b0;
      repeat (8) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      #1;
      check8({6'h00, pins_out}, 8'h01);
      check8({6'h00, pins_oe}, 8'h00);
      rd_chk(`UA_ADDR_CTRL, `UA_CTRL_RST);
      rd_chk(`UA_ADDR_MASK, `UA_MASK_RST);
      rd_chk(`UA_ADDR_BAUD, {4'h0, `UA_BAUD_RST});
      rd_chk(`UA_ADDR_PRE_LO, 8'(`UA_PRE_RST));
      rd_chk(`UA_ADDR_PRE_HI, 8'(`UA_PRE_RST >> 8));
      rd_chk(4'h9, 8'h00);
      // Prescaler mode with a 16-cycle bit, then a 26-cycle bit from the odd prescaler value 25.
      wr(`UA_ADDR_PRE_LO, 8'h0F);
      wr(`UA_ADDR_PRE_HI, 8'h00);
      wr(`UA_ADDR_CTRL, 8'h23);
      repeat (2) @(posedge clk_sys_in);
      check8({6'h00, pins_oe}, 8'h01);
      tx_chk(8'hA5);
      rx_chk(8'h3C, 1'b0, 1'b0, 8'h01);
      wr(`UA_ADDR_PRE_LO, 8'h19);
      bit_cyc <= 16'h001A;
      tx_chk(8'h5A);
      rx_chk(8'hC6, 1'b0, 1'b1, 8'h05);
      // Both directions at once must show both causes.
      fork
         wr(`UA_ADDR_TXDATA, 8'h81);
         u_far.send(8'h7E, 1'b0, 1'b0);
      join
      wait_st(8'h03);
      check8(u_far.got_byte, 8'h81);
      rd_chk(`UA_ADDR_RXDATA, 8'h7E);
      wr(`UA_ADDR_STATUS, 8'h1F);
      // Two bytes with no read between them.
      u_far.send(8'h11, 1'b0, 1'b0);
      u_far.send(8'h22, 1'b0, 1'b0);
      wait_st(8'h09);
      rd_chk(`UA_ADDR_RXDATA, 8'h22);
      wr(`UA_ADDR_MASK, 8'h08);
      repeat (3) @(posedge clk_sys_in);
      check8({7'h00, irq}, 8'h01);
      wr(`UA_ADDR_MASK, 8'h00);
      repeat (3) @(posedge clk_sys_in);
      check8({7'h00, irq}, 8'h00);
      wr(`UA_ADDR_STATUS, 8'h1F);
      // Parity in both senses, good and spoilt.
      for (int o = 0; o < 2; o++) begin
         // The far end must see the new parity setting before its first frame.
         par_en <= 1'b1;
         par_odd <= o[0];
         wr(`UA_ADDR_CTRL, 8'h27 | 8'(o << 3));
         rx_chk(8'h4D + 8'(o), 1'b0, 1'b0, 8'h01);
         rx_chk(8'h96, 1'b1, 1'b0, 8'h11);
         tx_chk(8'h69 + 8'(o));
         check8({7'h00, u_far.got_par_ok}, 8'h01);
      end
      // Calibrated rates, the fastest among them.
      par_en <= 1'b0;
      wr(`UA_ADDR_CTRL, 8'h33);
      for (int i = 0; i < 3; i++) begin
         wr(`UA_ADDR_BAUD, {4'h0, idx_tab[i]});
         bit_cyc <= 16'((`UA_CLK_HZ + bps_tab[i] / 2) / bps_tab[i]);
         tx_chk(8'hC0 + 8'(i));
         rx_chk(8'h30 + 8'(i), 1'b0, 1'b0, 8'h01);
      end
      report_and_stop();
   end
endmodule // uart_with_baud_autocal_test
